/* design/rtcbt_sync.sv */
// Three-stage synchroniser for a level arriving from outside the clock.
// Assumes a free-running clock_in; output changes once stages 2 and 3 agree.
`timescale 1ns/1ps

module rtcbt_sync
	import rtcbt_pkg::*;
(
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic async_in,
	output logic level_out
);

	rtcbt_sync_type s_r;
	rtcbt_sync_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.ff1 = async_in;
		s_nxt.ff2 = s_r.ff1;
		s_nxt.ff3 = s_r.ff2;
		if (s_r.ff2 == s_r.ff3) begin
			s_nxt.level = s_r.ff3;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level_out = s_r.level;

endmodule

/* design/rtcbt_top.sv */
// Serial-clock stuck-low watchdog, oscillator-stop flag and dual-use
// square-wave / external-clock pin of a serial real-time clock.
// Assumes the two-wire slave logic sits beside it on the same clock and
// obeys bus_reset_out; control bits come from that logic's registers.
//
// Function
// - Reset serial bus interface when serial clock stays low for the timeout.
// - Detect any single serial clock low phase longer than minimum timeout.
// - After maximum timeout of low clock, interface is reset, ready for START.
// - On stuck-low clock, release the serial data line to its pull-up.
// - Timeout detection only while oscillator runs; none when stopped.
// - Set oscillator-stopped flag after oscillator stopped for detection delay.
// - Square-wave output offers 1Hz, 4kHz, 8kHz or 32kHz.
// - External-clock select: 0 gives open-drain output, 1 takes external clock.
// - Square wave runs on main supply; on battery only if enabled.
// - Serial data line is only driven low or released.
// - Oscillator-stop detection delay is 100 ms.
// - Halt bit stops the oscillator and with it timeout detection.
`timescale 1ns/1ps

module rtcbt_top
	import rtcbt_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = `RTCBT_TIMEOUT_CYC,
	parameter int unsigned OSF_CYC = `RTCBT_OSF_CYC,
	parameter int unsigned OSC_DEAD_CYC = `RTCBT_OSC_DEAD_CYC
)
(
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic scl_in,
	input wire logic xtal_in,
	input wire logic wave_out_clk_in_pin_in,
	input wire logic vcc_good_in,
	input wire rtcbt_ctrl_type ctrl_in,
	input wire logic slave_sda_low_in,
	input wire logic osf_clear_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic wave_out_clk_in_pin_out,
	output logic wave_out_clk_in_pin_oe_out,
	output logic bus_reset_out,
	output logic osc_running_out,
	output logic osc_stopped_flag_out,
	output logic tick_1hz_out
);

	localparam int CW = `RTCBT_CNT_W;
	localparam logic [`RTCBT_CNT_W-1:0] TO_LAST = CW'(TIMEOUT_CYC - 1);
	localparam logic [`RTCBT_CNT_W-1:0] OSF_LAST = CW'(OSF_CYC - 1);
	localparam logic [`RTCBT_CNT_W-1:0] DEAD_LIM = CW'(OSC_DEAD_CYC);
	localparam logic [`RTCBT_CNT_W-1:0] CNT_ONE = CW'(1);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic scl_s;
	logic xtal_s;
	logic pin_s;
	logic vcc_s;

	rtcbt_sync u_sync_scl (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.async_in(scl_in),
		.level_out(scl_s)
	);

	rtcbt_sync u_sync_xtal (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.async_in(xtal_in),
		.level_out(xtal_s)
	);

	rtcbt_sync u_sync_pin (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.async_in(wave_out_clk_in_pin_in),
		.level_out(pin_s)
	);

	rtcbt_sync u_sync_vcc (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.async_in(vcc_good_in),
		.level_out(vcc_s)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	rtcbt_state_type s_r;
	rtcbt_state_type s_nxt;

	always_comb begin
		logic osc_edge;
		logic scl_low;
		logic osf_set;
		logic src;
		logic src_rise;
		logic wave_level;
		logic wave_on;
		osc_edge = 1'b0;
		scl_low = 1'b0;
		osf_set = 1'b0;
		src = 1'b0;
		src_rise = 1'b0;
		wave_level = 1'b0;
		wave_on = 1'b0;

		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		s_nxt.sda_o = 1'b0;
		s_nxt.wave_o = 1'b0;

		// Oscillator activity: halted crystal edges are ignored
		osc_edge = !ctrl_in.osc_halt && (xtal_s != s_r.xtal_q);
		s_nxt.xtal_q = xtal_s;
		if (osc_edge) begin
			s_nxt.dead_cnt = '0;
		end else if (s_r.dead_cnt < DEAD_LIM) begin
			s_nxt.dead_cnt = s_r.dead_cnt + CNT_ONE;
		end
		s_nxt.osc_run = !ctrl_in.osc_halt && (s_nxt.dead_cnt < DEAD_LIM);

		// Oscillator-stop delay and sticky flag; set beats clear
		if (s_r.osc_run) begin
			s_nxt.stop_cnt = '0;
		end else if (s_r.stop_cnt != OSF_LAST) begin
			s_nxt.stop_cnt = s_r.stop_cnt + CNT_ONE;
		end
		osf_set = !s_r.osc_run && (s_r.stop_cnt == OSF_LAST);
		if (osf_clear_in) begin
			s_nxt.osc_stopped_flag = 1'b0;
		end
		if (osf_set) begin
			s_nxt.osc_stopped_flag = 1'b1;
		end

		// Serial clock stuck-low watchdog
		scl_low = !scl_s;
		case (s_r.to_state)
			TO_IDLE: begin
				s_nxt.to_cnt = '0;
				if (scl_low && s_r.osc_run) begin
					s_nxt.to_state = TO_COUNT;
				end
			end
			TO_COUNT: begin
				if (!scl_low || !s_r.osc_run) begin
					s_nxt.to_state = TO_IDLE;
					s_nxt.to_cnt = '0;
				end else if (s_r.to_cnt == TO_LAST) begin
					s_nxt.to_state = TO_STUCK;
				end else begin
					s_nxt.to_cnt = s_r.to_cnt + CNT_ONE;
				end
			end
			TO_STUCK: begin
				// Held in reset until the clock rises again or the oscillator stops
				if (!scl_low || !s_r.osc_run) begin
					s_nxt.to_state = TO_IDLE;
					s_nxt.to_cnt = '0;
				end
			end
			default: begin
				s_nxt.to_state = TO_IDLE;
				s_nxt.to_cnt = '0;
			end
		endcase
		s_nxt.bus_rst = (s_nxt.to_state == TO_STUCK);
		s_nxt.sda_oe = slave_sda_low_in && (s_nxt.to_state != TO_STUCK);

		// Timekeeping source: crystal or external clock on the pin
		src = ctrl_in.ext_clk_select ? pin_s : (xtal_s && !ctrl_in.osc_halt);
		src_rise = src && !s_r.src_q;
		s_nxt.src_q = src;
		if (src_rise) begin
			s_nxt.div = s_r.div + `RTCBT_DIV_W'(1);
			if (s_r.div == `RTCBT_DIV_LAST) begin
				s_nxt.tick = 1'b1;
			end
		end

		// Square-wave rate select
		case ({ctrl_in.rate_sel_hi, ctrl_in.rate_sel_lo})
			`RTCBT_RATE_1HZ: wave_level = s_r.div[`RTCBT_TAP_1HZ];
			`RTCBT_RATE_4KHZ: wave_level = s_r.div[`RTCBT_TAP_4KHZ];
			`RTCBT_RATE_8KHZ: wave_level = s_r.div[`RTCBT_TAP_8KHZ];
			`RTCBT_RATE_32KHZ: wave_level = s_r.src_q;
			default: wave_level = 1'b1;
		endcase

		// Open-drain output only in output mode, gated by supply domain
		wave_on = ctrl_in.sqw_out_enable && !ctrl_in.ext_clk_select && s_r.osc_run
			&& (vcc_s || ctrl_in.battery_sqw_enable);
		s_nxt.wave_oe = wave_on && !wave_level;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_r <= '{to_state: TO_IDLE, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------------
	assign sda_out = s_r.sda_o;
	assign sda_oe_out = s_r.sda_oe;
	assign wave_out_clk_in_pin_out = s_r.wave_o;
	assign wave_out_clk_in_pin_oe_out = s_r.wave_oe;
	assign bus_reset_out = s_r.bus_rst;
	assign osc_running_out = s_r.osc_run;
	assign osc_stopped_flag_out = s_r.osc_stopped_flag;
	assign tick_1hz_out = s_r.tick;

endmodule

/* include/rtcbt_cfg.svh */
// Constants for the bus-timeout, oscillator-stop and square-wave block.
// Assumes the system clock runs at 200 MHz; included by the package.
`ifndef RTCBT_CFG_SVH
`define RTCBT_CFG_SVH

// ----------------------------------------------------------------------
// Clock and counter widths
// ----------------------------------------------------------------------
`define RTCBT_CLK_MHZ 200
`define RTCBT_CNT_W 25
`define RTCBT_DIV_W 15

// ----------------------------------------------------------------------
// Times in their own units
// ----------------------------------------------------------------------
`define RTCBT_TIMEOUT_MIN_MS 25
`define RTCBT_TIMEOUT_MAX_MS 35
`define RTCBT_OSF_DELAY_MS 100
`define RTCBT_OSC_DEAD_US 100

// ----------------------------------------------------------------------
// Derived cycle counts at the system clock
// ----------------------------------------------------------------------
`define RTCBT_TIMEOUT_CYC (`RTCBT_TIMEOUT_MIN_MS * `RTCBT_CLK_MHZ * 1000)
`define RTCBT_OSF_CYC (`RTCBT_OSF_DELAY_MS * `RTCBT_CLK_MHZ * 1000)
`define RTCBT_OSC_DEAD_CYC (`RTCBT_OSC_DEAD_US * `RTCBT_CLK_MHZ)

// ----------------------------------------------------------------------
// Rate select encoding {rate_sel_hi, rate_sel_lo}
// ----------------------------------------------------------------------
`define RTCBT_RATE_1HZ 2'h0
`define RTCBT_RATE_4KHZ 2'h1
`define RTCBT_RATE_8KHZ 2'h2
`define RTCBT_RATE_32KHZ 2'h3

// ----------------------------------------------------------------------
// Divider taps (divider counts source rising edges)
// ----------------------------------------------------------------------
`define RTCBT_TAP_4KHZ 2
`define RTCBT_TAP_8KHZ 1
`define RTCBT_TAP_1HZ 14
`define RTCBT_DIV_LAST 15'h7fff

`endif

/* include/rtcbt_pkg.sv */
// Types shared by the bus-timeout / square-wave block and its synchroniser.
// Assumes rtcbt_cfg.svh is on the include path.
`include "rtcbt_cfg.svh"

package rtcbt_pkg;

	// ------------------------------------------------------------------
	// Control bits from the register logic
	// ------------------------------------------------------------------
	typedef struct packed {
		logic osc_halt;
		logic ext_clk_select;
		logic sqw_out_enable;
		logic rate_sel_hi;
		logic rate_sel_lo;
		logic battery_sqw_enable;
	} rtcbt_ctrl_type;

	// ------------------------------------------------------------------
	// Timeout watcher states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		TO_IDLE,
		TO_COUNT,
		TO_STUCK
	} rtcbt_to_state_type;

	// ------------------------------------------------------------------
	// Synchroniser state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic ff1;
		logic ff2;
		logic ff3;
		logic level;
	} rtcbt_sync_type;

	// ------------------------------------------------------------------
	// Main block state
	// ------------------------------------------------------------------
	typedef struct packed {
		rtcbt_to_state_type to_state;
		logic [`RTCBT_CNT_W-1:0] to_cnt;
		logic [`RTCBT_CNT_W-1:0] dead_cnt;
		logic [`RTCBT_CNT_W-1:0] stop_cnt;
		logic [`RTCBT_DIV_W-1:0] div;
		logic osc_run;
		logic osc_stopped_flag;
		logic xtal_q;
		logic src_q;
		logic tick;
		logic bus_rst;
		logic sda_oe;
		logic sda_o;
		logic wave_oe;
		logic wave_o;
	} rtcbt_state_type;

endpackage

/* verification/rtcbt_asserts.sv */
// Port checker for the stuck-clock watchdog, oscillator flag and wave pin.
// Assumes it is bound to rtcbt_top and shares its clock and reset.
`timescale 1ns/1ps
module rtcbt_asserts
	import rtcbt_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = 200,
	parameter int unsigned OSF_CYC = 300
)
(
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic scl_in,
	input wire logic vcc_good_in,
	input wire rtcbt_ctrl_type ctrl_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic wave_out_clk_in_pin_oe_out,
	input wire logic bus_reset_out,
	input wire logic osc_running_out,
	input wire logic osc_stopped_flag_out
);
	int low_c;
	int stop_c;
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (!arst_n_in);
	// ---
	// Raw low-clock and stopped-oscillator counts
	// ---
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			low_c <= 0;
			stop_c <= 0;
		end else begin
			low_c <= (scl_in || !osc_running_out) ? 0 : low_c + 1;
			stop_c <= osc_running_out ? 0 : stop_c + 1;
		end
	end
	sequence s_scl_up;
		scl_in [*8];
	endsequence
	sequence s_no_osc;
		!osc_running_out [*2];
	endsequence
	a_sda_low_only: assert property (sda_out == 1'b0)
		else $error("data line driven high");
	a_sda_release_stuck: assert property (bus_reset_out |-> !sda_oe_out)
		else $error("data line held during bus reset");
	a_timeout_not_early: assert property ($rose(bus_reset_out) |-> low_c >= TIMEOUT_CYC)
		else $error("bus reset too early");
	a_timeout_by_max: assert property (low_c == TIMEOUT_CYC + 12 |-> bus_reset_out)
		else $error("bus reset missing");
	a_scl_high_clear: assert property (s_scl_up |-> !bus_reset_out)
		else $error("bus reset kept with clock high");
	a_no_osc_no_reset: assert property (s_no_osc |-> !bus_reset_out)
		else $error("bus reset without oscillator");
	a_halt_stops_osc: assert property (ctrl_in.osc_halt |=> !osc_running_out)
		else $error("oscillator runs while halted");
	a_osf_after_delay: assert property (stop_c == OSF_CYC + 4 |-> osc_stopped_flag_out)
		else $error("stop flag missing");
	a_ext_pin_quiet: assert property (ctrl_in.ext_clk_select |=> !wave_out_clk_in_pin_oe_out)
		else $error("pin driven in clock input mode");
	a_sqw_gate_off: assert property (!ctrl_in.sqw_out_enable |=> !wave_out_clk_in_pin_oe_out)
		else $error("pin driven while disabled");
	a_battery_gate: assert property ((!vcc_good_in && !ctrl_in.battery_sqw_enable) [*8]
		|-> !wave_out_clk_in_pin_oe_out) else $error("pin driven on battery");
endmodule
bind rtcbt_top rtcbt_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC), .OSF_CYC(OSF_CYC)) u_chk (
	.clock_in(clock_in), .arst_n_in(arst_n_in), .scl_in(scl_in), .vcc_good_in(vcc_good_in),
	.ctrl_in(ctrl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
	.wave_out_clk_in_pin_oe_out(wave_out_clk_in_pin_oe_out), .bus_reset_out(bus_reset_out),
	.osc_running_out(osc_running_out), .osc_stopped_flag_out(osc_stopped_flag_out));

/* verification/rtcbt_master.sv */
// Serial bus master model: supplies the serial clock only.
// Assumes the bench steers it; idle clock rests high on the pull-up.
`timescale 1ns/1ps
module rtcbt_master (
	input wire logic run_in,
	input wire logic hold_low_in,
	output logic scl_out
);
	logic ph = 1'b1;
	always #32 ph = run_in ? !ph : 1'b1;
	assign scl_out = hold_low_in ? 1'b0 : ph;
endmodule

/* verification/rtcbt_top_tb_top.sv */
// Self-checking bench for rtcbt_top with a serial clock master model.
// Assumes the checker is bound to the design; crystal runs at 80 ns.
`timescale 1ns/1ps
module rtcbt_top_tb_top;
	import rtcbt_pkg::*;
	localparam int unsigned TO = 200;
	localparam int unsigned OSC_STOPPED_FLAG = 300;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic xtal = 1'b0;
	logic vcc = 1'b1;
	logic slave = 1'b0;
	logic clr = 1'b0;
	logic run = 1'b0;
	logic hold = 1'b0;
	rtcbt_ctrl_type ctrl = 6'h0e;
	logic scl, sda, sda_oe, pin, pin_o, pin_oe, brst, orun, osc_stopped_flag, tick;
	int n_fail = 0;
	int checked = 0;
	logic [15:0] rows [8] = '{16'h4e10, 16'h4c40, 16'h4a80, 16'h4800,
		16'h4600, 16'h5e00, 16'h0e00, 16'h0f10};
	always #2.5 clk = !clk;
	always #40 xtal = !xtal;
	assign pin = pin_oe ? pin_o : 1'b1;
	rtcbt_master u_master (.run_in(run), .hold_low_in(hold), .scl_out(scl));
	rtcbt_top #(.TIMEOUT_CYC(TO), .OSF_CYC(OSC_STOPPED_FLAG), .OSC_DEAD_CYC(40)) dut (
		.clock_in(clk), .arst_n_in(rst_n), .scl_in(scl), .xtal_in(xtal),
		.wave_out_clk_in_pin_in(pin), .vcc_good_in(vcc), .ctrl_in(ctrl),
		.slave_sda_low_in(slave), .osf_clear_in(clr), .sda_out(sda), .sda_oe_out(sda_oe),
		.wave_out_clk_in_pin_out(pin_o), .wave_out_clk_in_pin_oe_out(pin_oe),
		.bus_reset_out(brst), .osc_running_out(orun), .osc_stopped_flag_out(osc_stopped_flag),
		.tick_1hz_out(tick));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("fails=%0d checks=%0d", n_fail, checked);
		if (n_fail == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Cycles between two rises of the pin drive, 0 if fewer
	task automatic measure(output int p);
		int i;
		int a;
		logic prev;
		p = 0;
		a = -1;
		prev = pin_oe;
		for (i = 0; i < 600; i++) begin
			step(1);
			if (pin_oe === 1'b1 && prev === 1'b0) begin
				if (a >= 0 && p == 0) p = i - a;
				a = i;
			end
			prev = pin_oe;
		end
	endtask
	initial begin
		#100000;
		n_fail++;
		wrap_up();
	end
	// ---
	// Main sequence
	// ---
	initial begin
		int p;
		int i;
		slave = 1'b1;
		step(8);
		check({sda, sda_oe, pin_oe, brst, orun, osc_stopped_flag, tick, pin_o}, 0);
		rst_n = 1'b1;
		slave = 1'b0;
		step(20);
		check(orun, 1);
		for (i = 0; i < 8; i++) begin
			ctrl = rows[i][13:8];
			vcc = rows[i][14];
			step(12);
			measure(p);
			check(p, {24'h0, rows[i][7:0]});
		end
		ctrl = 6'h0e;
		vcc = 1'b1;
		slave = 1'b1;
		hold = 1'b1;
		step(TO - 10);
		check(brst, 0);
		step(25);
		check({brst, sda_oe}, 2);
		hold = 1'b0;
		step(10);
		check({brst, sda_oe}, 1);
		run = 1'b1;
		step(2000);
		check(brst, 0);
		run = 1'b0;
		slave = 1'b0;
		ctrl = 6'h2e;
		step(2);
		check(orun, 0);
		hold = 1'b1;
		step(OSC_STOPPED_FLAG - 10);
		check({brst, osc_stopped_flag}, 0);
		step(20);
		check(osc_stopped_flag, 1);
		ctrl = 6'h0e;
		hold = 1'b0;
		step(20);
		check({orun, osc_stopped_flag}, 3);
		clr = 1'b1;
		step(1);
		clr = 1'b0;
		step(1);
		check(osc_stopped_flag, 0);
		slave = 1'b1;
		step(4);
		rst_n = 1'b0;
		step(2);
		check({sda_oe, pin_oe, orun, osc_stopped_flag}, 0);
		rst_n = 1'b1;
		step(4);
		wrap_up();
	end
endmodule
